// *** design/ddr3_mode_map.svh ***
`ifndef DDR3_MODE_MAP_SVH
`define DDR3_MODE_MAP_SVH

// ---------------------------------------------------------------
// command bank codes
// ---------------------------------------------------------------
`define BANK_FIRST      3'h1
`define BANK_SECOND     3'h2
`define BANK_THIRD      3'h3

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DLL_OFF_BIT     0
`define NOM_BIT_A       2
`define AL_LSB          3
`define NOM_BIT_B       6
`define LEVEL_BIT       7
`define NOM_BIT_C       9
`define QOFF_BIT        12
`define CWL_LSB         3
`define RTT_WR_LSB      9
`define PAT_EN_BIT      2
`define PAT_LOC_LSB     0
`define AUTO_PRE_BIT    10

// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define MODE_RST        14'h0000
`define CWL_BASE        6'h05
`define CL_MAX          6'h10
`define PATTERN_WORD    8'h55
`define WR_BURST_CYC    3'h4
`endif

// *** design/ddr3_mode_pkg.sv ***
package ddr3_mode_pkg;
   // posted command as it travels the delay pipeline
   typedef struct packed {
      logic valid;
      logic write;
      logic auto_pre;
      logic pattern;
   } cmd_entry_t;

   // termination currently presented
   typedef enum logic [1:0] {
      TERM_OFF = 2'b00,
      TERM_NOM = 2'b01,
      TERM_WR  = 2'b10
   } term_sel_t;

   // readout source for reads
   typedef enum logic {
      SRC_ARRAY   = 1'b0,
      SRC_PATTERN = 1'b1
   } read_src_t;
endpackage : ddr3_mode_pkg

// *** design/term_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface term_if;
   import ddr3_mode_pkg::*;
   logic [2:0] rtt_nom;
   logic [1:0] rtt_wr;
   logic       level_on;
   logic       dll_off;
   logic       odt_req;
   logic       wr_window;
   logic [2:0] rtt_code;
   term_sel_t  sel;

   modport ctrl (output rtt_nom, rtt_wr, level_on, dll_off, odt_req,
                 output wr_window, input rtt_code, sel);
   modport term (input rtt_nom, rtt_wr, level_on, dll_off, odt_req,
                 input wr_window, output rtt_code, sel);
endinterface : term_if
`default_nettype wire

// *** design/cmd_delay_line.sv ***
`timescale 1ns/10ps
`default_nettype none
module cmd_delay_line
   import ddr3_mode_pkg::*;
#(
   parameter int DEPTH = 32
) (
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   input  wire cmd_entry_t             cmd_in,
   output cmd_entry_t [DEPTH-1:0]      stage_ff
);
   initial begin
      if (DEPTH < 2) $error("delay depth too small");
   end

   // one slot per cycle, a command in stage index i is i+1 cycles old
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         stage_ff <= '0;
      end else begin
         stage_ff <= {stage_ff[DEPTH-2:0], cmd_in};
      end
   end
endmodule : cmd_delay_line
`default_nettype wire

// *** design/term_select.sv ***
`timescale 1ns/10ps
`default_nettype none
module term_select
   import ddr3_mode_pkg::*;
(
   input  wire logic  sys_clk,
   input  wire logic  sys_rst,
   term_if.term       tif
);
   logic      dyn_ok;
   logic      nom_on;
   term_sel_t nxt_sel;

   // dynamic switching only outside leveling and with delay loop on
   assign dyn_ok = (tif.rtt_wr != 2'h0) && !tif.level_on
                   && !tif.dll_off;
   assign nom_on = (tif.rtt_nom != 3'h0);

   // pick termination source
   always_comb begin
      nxt_sel = TERM_OFF;
      if (tif.odt_req) begin
         if (tif.wr_window && dyn_ok) begin
            nxt_sel = TERM_WR;
         end else if (nom_on) begin
            nxt_sel = TERM_NOM;
         end
      end
   end

   // registered selection and code
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tif.sel      <= TERM_OFF;
         tif.rtt_code <= 3'h0;
      end else begin
         tif.sel <= nxt_sel;
         case (nxt_sel)
            TERM_NOM: tif.rtt_code <= tif.rtt_nom;
            TERM_WR:  tif.rtt_code <= {1'b0, tif.rtt_wr};
            default:  tif.rtt_code <= 3'h0;
         endcase
      end
   end
endmodule : term_select
`default_nettype wire

// *** design/ddr3_mode_logic.sv ***
`include "ddr3_mode_map.svh"
`timescale 1ns/10ps
`default_nettype none
module ddr3_mode_logic
   import ddr3_mode_pkg::*;
#(
   parameter int DEPTH = 32
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic [2:0]  bank,
   input  wire logic [13:0] addr,
   input  wire logic        odt_pin,
   input  wire logic [5:0]  read_column_latency,
   input  wire logic        wl_strobe_edge,
   input  wire logic        wl_clk_level,
   output logic             exec_valid,
   output logic             exec_write,
   output logic             exec_auto_pre,
   output logic             read_data_start,
   output logic             read_from_pattern,
   output logic             write_data_start,
   output logic [5:0]       total_read_latency,
   output logic [5:0]       total_write_latency,
   output logic             out_drive_en,
   output logic             wl_active,
   output logic             wl_feedback,
   output logic             pattern_active,
   output logic [7:0]       pattern_data,
   output logic [1:0]       pattern_loc,
   output logic [2:0]       rtt_code,
   output term_sel_t        term_sel
);
   initial begin
      if (DEPTH < 2 * `CL_MAX) $error("pipeline shorter than latency");
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // additive latency code to cycles
   function automatic logic [5:0] al_cycles(input logic [1:0] code,
                                            input logic [5:0] cl);
      case (code)
         2'h1:    al_cycles = cl - 6'h01;
         2'h2:    al_cycles = cl - 6'h02;
         default: al_cycles = 6'h00;
      endcase
   endfunction : al_cycles

   // entry that is d cycles old
   function automatic cmd_entry_t tap(input logic [5:0] d,
                                      input cmd_entry_t now,
                                      input cmd_entry_t [DEPTH-1:0] st);
      if (d == 6'h00) begin
         tap = now;
      end else begin
         tap = st[d - 6'h01];
      end
   endfunction : tap

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   logic mrs_cmd;
   logic col_cmd;
   logic wr_cmd;

   assign mrs_cmd = !cs_n && !ras_n && !cas_n && !we_n;
   // column command never blocked, even right after activate
   assign col_cmd = !cs_n && ras_n && !cas_n;
   assign wr_cmd  = col_cmd && !we_n;

   // ---------------------------------------------------------------
   // mode registers
   // ---------------------------------------------------------------
   logic [13:0] first_mode_register_ff;
   logic [13:0] second_mode_register_ff;
   logic [13:0] third_mode_register_ff;

   // first register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         first_mode_register_ff <= `MODE_RST;
      end else if (mrs_cmd && bank == `BANK_FIRST) begin
         first_mode_register_ff <= addr;
      end
   end

   // second register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         second_mode_register_ff <= `MODE_RST;
      end else if (mrs_cmd && bank == `BANK_SECOND) begin
         second_mode_register_ff <= addr;
      end
   end

   // third register, reset also leaves pattern mode
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         third_mode_register_ff <= `MODE_RST;
      end else if (mrs_cmd && bank == `BANK_THIRD) begin
         third_mode_register_ff <= addr;
      end
   end

   // ---------------------------------------------------------------
   // field extraction, reserved bits unused
   // ---------------------------------------------------------------
   logic [1:0] al_code;
   logic [2:0] cwl_code;
   logic [1:0] rtt_wr;
   logic [2:0] rtt_nom;
   logic       qoff;
   logic       level_on;
   logic       dll_off;
   read_src_t  read_src;

   assign al_code  = first_mode_register_ff[`AL_LSB +: 2];
   assign qoff     = first_mode_register_ff[`QOFF_BIT];
   assign level_on = first_mode_register_ff[`LEVEL_BIT];
   assign dll_off  = first_mode_register_ff[`DLL_OFF_BIT];
   assign rtt_nom  = {first_mode_register_ff[`NOM_BIT_C],
                      first_mode_register_ff[`NOM_BIT_B],
                      first_mode_register_ff[`NOM_BIT_A]};
   // only the documented fields are read back
   assign cwl_code = second_mode_register_ff[`CWL_LSB +: 3];
   assign rtt_wr   = second_mode_register_ff[`RTT_WR_LSB +: 2];
   assign read_src = read_src_t'(third_mode_register_ff[`PAT_EN_BIT]);

   // ---------------------------------------------------------------
   // latency composition
   // ---------------------------------------------------------------
   logic [5:0] al_lat;
   logic [5:0] cwl_lat;
   logic [5:0] rd_lat;
   logic [5:0] wr_lat;

   assign al_lat  = al_cycles(al_code, read_column_latency);
   // whole cycles only, no half steps
   assign cwl_lat = `CWL_BASE + {3'h0, cwl_code};
   assign rd_lat  = al_lat + read_column_latency;
   assign wr_lat  = al_lat + cwl_lat;

   // latency report
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         total_read_latency  <= 6'h00;
         total_write_latency <= 6'h00;
      end else begin
         total_read_latency  <= rd_lat;
         total_write_latency <= wr_lat;
      end
   end

   // ---------------------------------------------------------------
   // posted command pipeline
   // ---------------------------------------------------------------
   cmd_entry_t             cmd_now;
   cmd_entry_t [DEPTH-1:0] stage;
   cmd_entry_t             tap_exec;
   cmd_entry_t             tap_rd;
   cmd_entry_t             tap_wr;

   // tag the read with its source when it is posted
   always_comb begin
      cmd_now          = '0;
      cmd_now.valid    = col_cmd;
      cmd_now.write    = wr_cmd;
      cmd_now.auto_pre = addr[`AUTO_PRE_BIT];
      cmd_now.pattern  = col_cmd && !wr_cmd
                         && read_src == SRC_PATTERN;
   end

   cmd_delay_line #(
      .DEPTH    (DEPTH)
   ) u_delay (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .cmd_in   (cmd_now),
      .stage_ff (stage)
   );

   assign tap_exec = tap(al_lat, cmd_now, stage);
   assign tap_rd   = tap(rd_lat, cmd_now, stage);
   assign tap_wr   = tap(wr_lat, cmd_now, stage);

   // internal execution after additive latency
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         exec_valid    <= 1'b0;
         exec_write    <= 1'b0;
         exec_auto_pre <= 1'b0;
      end else begin
         exec_valid    <= tap_exec.valid;
         exec_write    <= tap_exec.valid && tap_exec.write;
         exec_auto_pre <= tap_exec.valid && tap_exec.auto_pre;
      end
   end

   // first data bit markers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         read_data_start   <= 1'b0;
         read_from_pattern <= 1'b0;
         write_data_start  <= 1'b0;
      end else begin
         read_data_start   <= tap_rd.valid && !tap_rd.write;
         read_from_pattern <= tap_rd.valid && tap_rd.pattern;
         write_data_start  <= tap_wr.valid && tap_wr.write;
      end
   end

   // ---------------------------------------------------------------
   // readout pattern mode
   // ---------------------------------------------------------------
   // location bits only count while the mode is on
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pattern_active <= 1'b0;
         pattern_loc    <= 2'h0;
         pattern_data   <= 8'h00;
      end else begin
         case (read_src)
            SRC_PATTERN: begin
               pattern_active <= 1'b1;
               pattern_loc    <=
                  third_mode_register_ff[`PAT_LOC_LSB +: 2];
               pattern_data   <= `PATTERN_WORD;
            end
            default: begin
               pattern_active <= 1'b0;
               pattern_loc    <= 2'h0;
               pattern_data   <= 8'h00;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // output disable and write leveling
   // ---------------------------------------------------------------
   // drivers for data and strobes released when disabled
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         out_drive_en <= 1'b1;
         wl_active    <= 1'b0;
      end else begin
         out_drive_en <= !qoff;
         wl_active    <= level_on;
      end
   end

   // sampled clock level returned per strobe edge
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wl_feedback <= 1'b0;
      end else if (!level_on) begin
         wl_feedback <= 1'b0;
      end else if (wl_strobe_edge) begin
         wl_feedback <= wl_clk_level;
      end
   end

   // ---------------------------------------------------------------
   // write window and termination
   // ---------------------------------------------------------------
   logic [2:0] wr_win_ff;

   // burst length of termination hold per write
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wr_win_ff <= 3'h0;
      end else if (tap_wr.valid && tap_wr.write) begin
         wr_win_ff <= `WR_BURST_CYC;
      end else if (wr_win_ff != 3'h0) begin
         wr_win_ff <= wr_win_ff - 3'h1;
      end
   end

   term_if tif ();

   assign tif.rtt_nom   = rtt_nom;
   assign tif.rtt_wr    = rtt_wr;
   assign tif.level_on  = level_on;
   assign tif.dll_off   = dll_off;
   assign tif.odt_req   = odt_pin;
   assign tif.wr_window = (wr_win_ff != 3'h0)
                          || (tap_wr.valid && tap_wr.write);
   assign rtt_code      = tif.rtt_code;
   assign term_sel      = tif.sel;

   term_select u_term (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .tif     (tif.term)
   );
endmodule : ddr3_mode_logic
`default_nettype wire

// *** verification/ddr3_mode_logic_chk.sv ***
`include "ddr3_mode_map.svh"
`timescale 1ns/10ps
`default_nettype none
module ddr3_mode_logic_chk
   import ddr3_mode_pkg::*;
#(
   parameter int DEPTH = 32
) (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [2:0]  bank,
   input wire logic [13:0] addr,
   input wire logic        odt_pin,
   input wire logic        wl_strobe_edge,
   input wire logic        wl_clk_level,
   input wire logic        read_data_start,
   input wire logic        read_from_pattern,
   input wire logic        out_drive_en,
   input wire logic        wl_active,
   input wire logic        wl_feedback,
   input wire logic        pattern_active,
   input wire logic [7:0]  pattern_data,
   input wire logic [1:0]  pattern_loc,
   input wire logic [2:0]  rtt_code,
   input wire term_sel_t   term_sel
);
   // ---------------
   // command decode
   // ---------------
   logic set_cmd;
   assign set_cmd = !cs_n && !ras_n && !cas_n && !we_n;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   // ---------------
   // mode register effects
   // ---------------
   chk_drive_follows: assert property (
      set_cmd && bank == `BANK_FIRST ##1 !set_cmd
      |=> out_drive_en == !$past(addr[`QOFF_BIT], 2))
      else $error("output enable does not follow first register");
   chk_level_follows: assert property (
      set_cmd && bank == `BANK_FIRST ##1 !set_cmd
      |=> wl_active == $past(addr[`LEVEL_BIT], 2))
      else $error("leveling flag does not follow first register");
   chk_pattern_enable: assert property (
      set_cmd && bank == `BANK_THIRD ##1 !set_cmd
      |=> pattern_active == $past(addr[`PAT_EN_BIT], 2))
      else $error("pattern mode does not follow third register");
   chk_loc_ignored: assert property (
      !pattern_active && !$past(pattern_active) |-> pattern_loc == 2'h0)
      else $error("pattern location shown while pattern mode off");
   chk_pattern_word: assert property (
      pattern_active && $past(pattern_active)
      |-> pattern_data == `PATTERN_WORD)
      else $error("pattern word wrong");
   chk_read_tag: assert property (
      read_from_pattern |-> read_data_start)
      else $error("pattern tag outside first read data cycle");

   // ---------------
   // leveling and termination
   // ---------------
   chk_feedback_sample: assert property (
      wl_active && wl_strobe_edge ##1 wl_active && !wl_strobe_edge
      |=> wl_feedback == $past(wl_clk_level, 2))
      else $error("leveling feedback not the sampled level");
   chk_level_no_wr: assert property (
      wl_active && $past(wl_active) |-> term_sel != TERM_WR)
      else $error("write termination used while leveling");
   chk_odt_low_off: assert property (
      !odt_pin ##1 !odt_pin |=> term_sel == TERM_OFF && rtt_code == 3'h0)
      else $error("termination on while request low");
endmodule : ddr3_mode_logic_chk

bind ddr3_mode_logic ddr3_mode_logic_chk #(.DEPTH(DEPTH)) u_chk (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(cs_n), .ras_n(ras_n),
   .cas_n(cas_n), .we_n(we_n), .bank(bank), .addr(addr),
   .odt_pin(odt_pin), .wl_strobe_edge(wl_strobe_edge),
   .wl_clk_level(wl_clk_level), .read_data_start(read_data_start),
   .read_from_pattern(read_from_pattern), .out_drive_en(out_drive_en),
   .wl_active(wl_active), .wl_feedback(wl_feedback),
   .pattern_active(pattern_active), .pattern_data(pattern_data),
   .pattern_loc(pattern_loc), .rtt_code(rtt_code), .term_sel(term_sel)
);
`default_nettype wire

// *** verification/ctrl_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ctrl_model (
   input  wire logic        sys_clk,
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic [2:0]       bank,
   output logic [13:0]      addr,
   output logic             odt_pin
);
   // deselected bus at time zero
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      bank = 3'h0;
      addr = 14'h0000;
      odt_pin = 1'b0;
   end

   // drive one command for the coming edge
   task automatic issue(input logic [3:0] c, input logic [2:0] b,
                        input logic [13:0] a);
      @(posedge sys_clk);
      {cs_n, ras_n, cas_n, we_n} <= c;
      bank <= b;
      addr <= a;
   endtask : issue

   // deselect; address no longer holds its value
   task automatic idle();
      @(posedge sys_clk);
      cs_n <= 1'b1;
      addr <= ~addr;
   endtask : idle

   // mode register write with reserved bits held low
   task automatic mrs(input logic [1:0] r, input logic [13:0] a);
      logic [13:0] keep;
      keep = (r == 2'h1) ? 14'h1AFF : (r == 2'h2) ? 14'h06FF : 14'h0007;
      issue(4'h0, {1'b0, r}, a & keep);
      idle();
   endtask : mrs
endmodule : ctrl_model
`default_nettype wire

// *** verification/ddr3_mode_logic_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module ddr3_mode_logic_test;
   import ddr3_mode_pkg::*;
   logic        sys_clk, sys_rst, wl_strobe_edge, wl_clk_level;
   logic        cs_n, ras_n, cas_n, we_n, odt_pin;
   logic        exec_valid, exec_write, exec_auto_pre, out_drive_en;
   logic        read_data_start, read_from_pattern, write_data_start;
   logic        wl_active, wl_feedback, pattern_active, ap, ew, pat, rds;
   logic [2:0]  bank, rtt_code, rcw;
   logic [13:0] addr;
   logic [5:0]  read_column_latency, total_read_latency, total_write_latency;
   logic [7:0]  pattern_data;
   logic [1:0]  pattern_loc;
   term_sel_t   term_sel, tsw;
   int          fail_count, comparisons, ke, kd, nexec;

   ctrl_model ctl (.sys_clk, .cs_n, .ras_n, .cas_n, .we_n, .bank, .addr,
                   .odt_pin);
   ddr3_mode_logic dut (.sys_clk, .sys_rst, .cs_n, .ras_n, .cas_n, .we_n,
      .bank, .addr, .odt_pin, .read_column_latency, .wl_strobe_edge,
      .wl_clk_level, .exec_valid, .exec_write, .exec_auto_pre,
      .read_data_start, .read_from_pattern, .write_data_start,
      .total_read_latency, .total_write_latency, .out_drive_en, .wl_active,
      .wl_feedback, .pattern_active, .pattern_data, .pattern_loc, .rtt_code,
      .term_sel);

   always #5 sys_clk = ~sys_clk;

   // ---------------
   // shared tasks
   // ---------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic final_report();
      if (fail_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report

   // mode register write, then let the fields settle
   task automatic cfg(input logic [1:0] r, input logic [13:0] a);
      ctl.mrs(r, a);
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : cfg

   // optional activate, one or two column commands, then time the answers
   task automatic run_col(input logic [3:0] c, input int two, input int act);
      ke = -1;
      kd = -1;
      nexec = 0;
      if (act) ctl.issue(4'h3, 3'h0, 14'h0000);
      ctl.issue(c, 3'h0, 14'h0400);
      if (two) ctl.issue(c, 3'h0, 14'h0000);
      ctl.idle();
      for (int k = two; k < 60; k++) begin
         #1;
         if (exec_valid === 1'b1) begin
            nexec++;
            if (ke < 0) begin
               ke = k;
               ap = exec_auto_pre;
               ew = exec_write;
            end
         end
         if (kd >= 0 && k == kd + 1) begin
            tsw = term_sel;
            rcw = rtt_code;
         end
         if (kd < 0 && (read_data_start | write_data_start) === 1'b1) begin
            kd = k;
            pat = read_from_pattern;
            rds = read_data_start;
         end
         @(posedge sys_clk);
      end
   endtask : run_col

   // ---------------
   // scenarios
   // ---------------
   task automatic t_reset();
      @(posedge sys_clk);
      #1;
      check(total_read_latency, 8'h06);
      check(total_write_latency, 8'h05);
      check({pattern_active, out_drive_en}, 8'h01);
   endtask : t_reset

   // every delay code and write column codes 0 to 3
   task automatic t_latency();
      int al;
      for (int i = 0; i < 4; i++) begin
         al = (i == 1 || i == 2) ? 6 - i : 0;
         cfg(2'h1, 14'(i) << 3);
         cfg(2'h2, 14'(i) << 3);
         check(total_read_latency, 8'(al + 6));
         check(total_write_latency, 8'(al + 5 + i));
         run_col(4'h5, 0, 1);
         check(8'(ke), 8'(al));
         check({pat, rds, ap, ew}, 8'h06);
         check(8'(kd), 8'(al + 6));
         run_col(4'h4, 0, 1);
         check({pat, rds, ap, ew}, 8'h03);
         check(8'(kd), 8'(al + 5 + i));
      end
   endtask : t_latency

   task automatic t_b2b();
      cfg(2'h1, 14'h0008);
      run_col(4'h5, 1, 1);
      check(8'(nexec), 8'h02);
      check(8'(ke), 8'h05);
   endtask : t_b2b

   task automatic t_drive();
      cfg(2'h1, 14'h1000);
      check(out_drive_en, 8'h00);
      cfg(2'h1, 14'h0000);
      check(out_drive_en, 8'h01);
   endtask : t_drive

   task automatic t_term();
      cfg(2'h2, 14'h0200);
      @(posedge sys_clk);
      ctl.odt_pin <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      check(term_sel, TERM_OFF);
      run_col(4'h4, 0, 1);
      check(tsw, TERM_WR);
      check(rcw, 8'h01);
      cfg(2'h1, 14'h02C0);
      check(term_sel, TERM_NOM);
      check(rtt_code, 8'h06);
      run_col(4'h4, 0, 1);
      check(tsw, TERM_NOM);
      check(rcw, 8'h06);
      cfg(2'h1, 14'h0001);
      run_col(4'h4, 0, 1);
      check(tsw, TERM_OFF);
      ctl.odt_pin <= 1'b0;
      cfg(2'h1, 14'h0000);
   endtask : t_term

   task automatic t_level();
      cfg(2'h1, 14'h0080);
      check(wl_active, 8'h01);
      @(posedge sys_clk);
      wl_clk_level <= 1'b1;
      wl_strobe_edge <= 1'b1;
      @(posedge sys_clk);
      wl_strobe_edge <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      check(wl_feedback, 8'h01);
      cfg(2'h1, 14'h0000);
      check(wl_feedback, 8'h00);
   endtask : t_level

   task automatic t_pattern();
      cfg(2'h3, 14'h0003);
      check({pattern_active, pattern_loc}, 8'h00);
      ctl.issue(4'h2, 3'h0, 14'h0400);
      ctl.idle();
      cfg(2'h3, 14'h0006);
      check({pattern_active, pattern_loc}, 8'h06);
      check(pattern_data, 8'h55);
      run_col(4'h5, 0, 0);
      check(pat, 8'h01);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      check({pattern_active, out_drive_en}, 8'h01);
   endtask : t_pattern

   // ---------------
   // main sequence and watchdog
   // ---------------
   initial begin
      sys_clk = 1'b0;
      sys_rst = 1'b1;
      wl_strobe_edge = 1'b0;
      wl_clk_level = 1'b0;
      read_column_latency = 6'h06;
      fail_count = 0;
      comparisons = 0;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_latency();
      t_b2b();
      t_drive();
      t_term();
      t_level();
      t_pattern();
      final_report();
   end

   initial begin
      #100000;
      fail_count++;
      final_report();
   end
endmodule : ddr3_mode_logic_test
`default_nettype wire
